// *** ppu_defs.vh ***
`ifndef PPU_DEFS_VH
`define PPU_DEFS_VH
// ----------------------------------------------------------------
// Parameter set geometry
// ----------------------------------------------------------------
`define PPU_SET_BYTES      128
`define PPU_IDX_W          7
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PPU_REG_CTRL       10'h000
`define PPU_REG_STATUS     10'h004
`define PPU_REG_IRQ_STATUS 10'h008
`define PPU_REG_IRQ_MASK   10'h00c
`define PPU_REG_DECODED    10'h010
`define PPU_REG_VERSION    10'h014
`define PPU_WIN_BASE       10'h200
`define PPU_CODEC_VERSION_BYTE 10'h200
`define PPU_SET_TAG_BYTE       10'h204
`define PPU_RESERVED_BYTE      10'h208
`define PPU_BIT_DEPTH_BYTE     10'h20c
`define PPU_CODING_FLAGS_BYTE  10'h210
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPU_CTRL_COMMIT    0
`define PPU_CTRL_CLEAR     1
`define PPU_IRQ_DONE       0
`define PPU_IRQ_INVALID    1
`define PPU_IRQ_REFUSED    2
`define PPU_IRQ_W          3
`define PPU_FLAG_BP        5
`define PPU_FLAG_RGB       4
`define PPU_FLAG_DROP      3
`define PPU_FLAG_VBR       2
`define PPU_FLAGS_RSVD     8'h3f
// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define PPU_IRQ_MASK_RST   3'h0
`define PPU_MAJOR_OK       4'h1
`define PPU_MINOR_ONE      4'h1
`define PPU_MINOR_TWO      4'h2
`define PPU_DEPTH_16       4'h0
`define PPU_DEPTH_14       4'he
`define PPU_DEPTH_15       4'hf
`endif

// *** ppu_param_store.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ppu_defs.vh"
module ppu_param_store #(
  parameter DEPTH = `PPU_SET_BYTES,
  parameter IDX_W = `PPU_IDX_W
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             clearAll,
  input  wire             wrEn,
  input  wire [IDX_W-1:0] wrIdx,
  input  wire [7:0]       wrByte,
  input  wire [IDX_W-1:0] rdIdx,
  output wire [7:0]       rdByte,
  output wire [7:0]       byte0,
  output wire [7:0]       byte1,
  output wire [7:0]       byte3,
  output wire [7:0]       byte4,
  output wire [7:0]       byte5,
  output wire             allCaptured
);
  reg [7:0]       mem [0:DEPTH-1];
  reg [DEPTH-1:0] seen;

  // ----------------------------------------------------------------
  // Byte storage; array holds no reset to stay a plain memory
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrByte;
    end
  end

  // Seen map: a set counts only once every index was written
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      seen <= {DEPTH{1'b0}};
    end else if (clearAll) begin
      seen <= {DEPTH{1'b0}};
    end else if (wrEn) begin
      seen[wrIdx] <= 1'b1;
    end
  end

  assign allCaptured = &seen;
  assign rdByte      = mem[rdIdx];
  assign byte0       = mem[0];
  assign byte1       = mem[1];
  assign byte3       = mem[3];
  assign byte4       = mem[4];
  assign byte5       = mem[5];
endmodule
`default_nettype wire

// *** ppu_field_decode.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ppu_defs.vh"
module ppu_field_decode (
  input  wire [7:0] byte0,
  input  wire [7:0] byte3,
  input  wire [7:0] byte4,
  input  wire [7:0] byte5,
  input  wire       chromaContainerMode,
  output wire [3:0] majorVersion,
  output wire [3:0] minorVersion,
  output reg  [4:0] sampleDepth,
  output reg  [4:0] lineStoreDepth,
  output wire [9:0] targetRate,
  output wire       badMajor,
  output wire       badMinor,
  output reg        badSampleDepth,
  output reg        badLineDepth,
  output wire       dropConflict
);
  wire       revTwo;
  wire [3:0] depthCode;
  wire [3:0] lineCode;

  assign majorVersion = byte0[7:4];
  assign minorVersion = byte0[3:0];
  assign revTwo       = (minorVersion == `PPU_MINOR_TWO);
  assign depthCode    = byte3[7:4];
  assign lineCode     = byte3[3:0];
  assign badMajor     = (majorVersion != `PPU_MAJOR_OK);
  assign badMinor     = (minorVersion != `PPU_MINOR_ONE) && !revTwo;
  assign targetRate   = {byte4[1:0], byte5};
  assign dropConflict = byte4[`PPU_FLAG_DROP] & chromaContainerMode;

  // Sample depth; the wide codes exist only in revision two
  always @* begin
    badSampleDepth = 1'b0;
    case (depthCode)
      4'h8: sampleDepth = 5'd8;
      4'ha: sampleDepth = 5'd10;
      4'hc: sampleDepth = 5'd12;
      `PPU_DEPTH_16: begin
        sampleDepth    = 5'd16;
        badSampleDepth = !revTwo;
      end
      `PPU_DEPTH_14: begin
        sampleDepth    = 5'd14;
        badSampleDepth = !revTwo;
      end
      default: begin
        sampleDepth    = 5'd0;
        badSampleDepth = 1'b1;
      end
    endcase
  end

  // Line-store depth; eight to thirteen map straight through
  always @* begin
    badLineDepth   = 1'b0;
    lineStoreDepth = {1'b0, lineCode};
    if (lineCode >= 4'h8 && lineCode <= 4'hd) begin
      lineStoreDepth = {1'b0, lineCode};
    end else if (lineCode == `PPU_DEPTH_16) begin
      lineStoreDepth = 5'd16;
      badLineDepth   = !revTwo;
    end else if (lineCode == `PPU_DEPTH_14 || lineCode == `PPU_DEPTH_15) begin
      badLineDepth   = !revTwo;
    end else begin
      lineStoreDepth = 5'd0;
      badLineDepth   = 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** ppu_unpacker.v ***
// Operation
// - Set is 128 bytes from index 0; all must arrive before decoding.
// - Multi-byte fields carry their high bits in the lower-numbered byte.
// - Major version is byte 0 high nibble; only 1 is valid.
// - Minor version is byte 0 low nibble; 1 or 2, zero unsupported.
// - Byte 3 high nibble gives sample depth 8, 10 or 12; others reserved.
// - Sample depth codes 16 and 14 bits valid only in revision two.
// - Byte 3 low nibble is line-store depth; deeper values get rounded.
// - Line-store codes 8 to 13 map directly; other codes reserved.
// - Line-store codes 16, 14 and 15 bits valid only in revision two.
// - Byte 4 bit 5 enables per-group block prediction choice.
// - Byte 4 bit 4 enables colour conversion; clear means YCbCr.
// - Byte 4 bit 3 makes decoder drop samples for a 4:2:2 picture.
// - Byte 4 bit 2 enables variable-rate operation.
// - Target rate is ten bits from byte 4 and byte 5, sixteenths.
`timescale 1ns/1ps
`default_nettype none
`include "ppu_defs.vh"
module ppu_unpacker (
  input  wire        clk,
  input  wire        rst,
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire        irq,
  input  wire        chromaContainerMode,
  input  wire [15:0] reconSample,
  input  wire        reconValid,
  input  wire        reconChroma,
  output reg  [15:0] storedSample,
  output reg         storedValid,
  output reg  [3:0]  majorVersion,
  output reg  [3:0]  minorVersion,
  output reg  [7:0]  setTag,
  output reg  [4:0]  sampleDepth,
  output reg  [4:0]  lineStoreDepth,
  output reg         blockPredictionEnable,
  output reg         colourConvert,
  output reg         sampleDrop,
  output reg         variableRate,
  output reg  [9:0]  targetRate,
  output reg         paramValid,
  output reg         paramInvalid
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 1'b0;
  localparam ST_LATCH = 1'b1;

  reg        ack;
  reg        state;
  reg        next_state;
  reg  [`PPU_IRQ_W-1:0] irqStatus;
  reg  [`PPU_IRQ_W-1:0] irqMask;
  reg  [`PPU_IRQ_W-1:0] irqSet;
  reg  [4:0] errorBits;
  reg  [31:0] next_readdata;
  wire       take;
  wire       takeWr;
  wire       inWindow;
  wire [6:0] winIdx;
  wire       commitReq;
  wire       clearReq;
  wire [7:0] rdByte;
  wire [7:0] byte0;
  wire [7:0] byte1;
  wire [7:0] byte3;
  wire [7:0] byte4;
  wire [7:0] byte5;
  wire       allCaptured;
  wire [3:0] decMajor;
  wire [3:0] decMinor;
  wire [4:0] decSample;
  wire [4:0] decLine;
  wire [9:0] decRate;
  wire       badMajor;
  wire       badMinor;
  wire       badSampleDepth;
  wire       badLineDepth;
  wire       dropConflict;
  wire       anyBad;
  wire [7:0] winRead;

  // ----------------------------------------------------------------
  // Avalon slave handshake
  // ----------------------------------------------------------------
  // One wait cycle on every access gives the array read a full cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign take            = (avs_read | avs_write) & ack;
  assign takeWr          = take & avs_write & avs_byteenable[0];
  assign inWindow        = (avs_address >= `PPU_WIN_BASE);
  assign winIdx          = avs_address[8:2];
  assign commitReq = takeWr && !inWindow && (avs_address == `PPU_REG_CTRL)
                     && avs_writedata[`PPU_CTRL_COMMIT];
  assign clearReq  = takeWr && !inWindow && (avs_address == `PPU_REG_CTRL)
                     && avs_writedata[`PPU_CTRL_CLEAR];

  // ----------------------------------------------------------------
  // Parameter byte store and field decode
  // ----------------------------------------------------------------
  ppu_param_store u_store (
    .clk         (clk),
    .rst         (rst),
    .clearAll    (clearReq),
    .wrEn        (takeWr & inWindow),
    .wrIdx       (winIdx),
    .wrByte      (avs_writedata[7:0]),
    .rdIdx       (winIdx),
    .rdByte      (rdByte),
    .byte0       (byte0),
    .byte1       (byte1),
    .byte3       (byte3),
    .byte4       (byte4),
    .byte5       (byte5),
    .allCaptured (allCaptured)
  );

  ppu_field_decode u_decode (
    .byte0               (byte0),
    .byte3               (byte3),
    .byte4               (byte4),
    .byte5               (byte5),
    .chromaContainerMode (chromaContainerMode),
    .majorVersion        (decMajor),
    .minorVersion        (decMinor),
    .sampleDepth         (decSample),
    .lineStoreDepth      (decLine),
    .targetRate          (decRate),
    .badMajor            (badMajor),
    .badMinor            (badMinor),
    .badSampleDepth      (badSampleDepth),
    .badLineDepth        (badLineDepth),
    .dropConflict        (dropConflict)
  );

  assign anyBad = badMajor | badMinor | badSampleDepth | badLineDepth
                  | dropConflict;

  // Reserved bits read back as zero whatever was written
  assign winRead = (winIdx == 7'd2) ? 8'h00 :
                   (winIdx == 7'd4) ? (rdByte & `PPU_FLAGS_RSVD) :
                   rdByte;

  // ----------------------------------------------------------------
  // Commit sequence
  // ----------------------------------------------------------------
  // Decode only a complete set; a partial one is refused
  always @* begin
    next_state = state;
    irqSet     = {`PPU_IRQ_W{1'b0}};
    case (state)
      ST_IDLE: begin
        if (commitReq && allCaptured) begin
          next_state = ST_LATCH;
        end else if (commitReq) begin
          irqSet[`PPU_IRQ_REFUSED] = 1'b1;
        end
      end
      ST_LATCH: begin
        next_state              = ST_IDLE;
        irqSet[`PPU_IRQ_DONE]    = 1'b1;
        irqSet[`PPU_IRQ_INVALID] = anyBad;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Decoded outputs change only at a commit, and paramValid also drops at a clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      majorVersion          <= 4'h0;
      minorVersion          <= 4'h0;
      setTag                <= 8'h00;
      sampleDepth           <= 5'd0;
      lineStoreDepth        <= 5'd0;
      blockPredictionEnable <= 1'b0;
      colourConvert         <= 1'b0;
      sampleDrop            <= 1'b0;
      variableRate          <= 1'b0;
      targetRate            <= 10'h000;
      paramValid            <= 1'b0;
      paramInvalid          <= 1'b0;
      errorBits             <= 5'h00;
    end else if (clearReq) begin
      paramValid            <= 1'b0;
    end else if (state == ST_LATCH) begin
      majorVersion          <= decMajor;
      minorVersion          <= decMinor;
      setTag                <= rdByteTag(byte1);
      sampleDepth           <= decSample;
      lineStoreDepth        <= decLine;
      blockPredictionEnable <= byte4[`PPU_FLAG_BP];
      colourConvert         <= byte4[`PPU_FLAG_RGB];
      sampleDrop            <= byte4[`PPU_FLAG_DROP];
      variableRate          <= byte4[`PPU_FLAG_VBR];
      targetRate            <= decRate;
      paramValid            <= ~anyBad;
      paramInvalid          <= anyBad;
      errorBits <= {dropConflict, badLineDepth, badSampleDepth, badMinor, badMajor};
    end
  end

  // Tag byte passes through untouched; every value is legal
  function [7:0] rdByteTag;
    input [7:0] tagByte;
    begin
      rdByteTag = tagByte;
    end
  endfunction

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // A new event in the clearing cycle survives the clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatus <= {`PPU_IRQ_W{1'b0}};
      irqMask   <= `PPU_IRQ_MASK_RST;
    end else begin
      if (takeWr && !inWindow && avs_address == `PPU_REG_IRQ_STATUS) begin
        irqStatus <= (irqStatus & ~avs_writedata[`PPU_IRQ_W-1:0]) | irqSet;
      end else begin
        irqStatus <= irqStatus | irqSet;
      end
      if (takeWr && !inWindow && avs_address == `PPU_REG_IRQ_MASK) begin
        irqMask <= avs_writedata[`PPU_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irqStatus & irqMask);

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  // Unmapped addresses read zero and swallow writes
  always @* begin
    next_readdata = 32'h0000_0000;
    if (inWindow) begin
      next_readdata = {24'h000000, winRead};
    end else begin
      case (avs_address)
        `PPU_REG_STATUS:
          next_readdata = {19'h00000, errorBits, 5'h00, paramInvalid,
                           paramValid, allCaptured};
        `PPU_REG_IRQ_STATUS:
          next_readdata = {29'h00000000, irqStatus};
        `PPU_REG_IRQ_MASK:
          next_readdata = {29'h00000000, irqMask};
        `PPU_REG_DECODED:
          next_readdata = {variableRate, sampleDrop, colourConvert,
                           blockPredictionEnable, 2'h0, targetRate,
                           3'h0, lineStoreDepth, 3'h0, sampleDepth};
        `PPU_REG_VERSION:
          next_readdata = {16'h0000, setTag, majorVersion, minorVersion};
        default:
          next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Line-store rounding of reconstructed samples
  // ----------------------------------------------------------------
  // Chroma grows one bit under colour conversion, capped at sixteen
  reg  [4:0]  compDepth;
  reg  [4:0]  dropBits;
  reg  [17:0] roundSum;
  reg  [15:0] roundOut;
  reg  [15:0] depthMax;

  always @* begin
    compDepth = sampleDepth;
    if (colourConvert && reconChroma && sampleDepth != 5'd16) begin
      compDepth = sampleDepth + 5'd1;
    end
    dropBits = 5'd0;
    if (compDepth > lineStoreDepth) begin
      dropBits = compDepth - lineStoreDepth;
    end
    depthMax = 16'hffff;
    if (compDepth < 5'd16) begin
      depthMax = (16'h0001 << compDepth[3:0]) - 16'h0001;
    end
    roundSum = {2'b00, reconSample};
    if (dropBits != 5'd0) begin
      roundSum = {2'b00, reconSample} + (18'h00001 << (dropBits - 5'd1));
      roundSum = (roundSum >> dropBits) << dropBits;
    end
    roundOut = roundSum[15:0];
    if (roundSum > {2'b00, depthMax}) begin
      roundOut = (depthMax >> dropBits) << dropBits;
    end
  end

  // Pass samples through unchanged until a valid set is in force
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      storedSample <= 16'h0000;
      storedValid  <= 1'b0;
    end else begin
      storedValid <= reconValid & paramValid;
      if (reconValid) begin
        storedSample <= paramValid ? roundOut : reconSample;
      end
    end
  end
endmodule
`default_nettype wire

// *** ppu_unpacker_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ppu_defs.vh"
module ppu_unpacker_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        reconValid,
  input wire logic        storedValid,
  input wire logic [3:0]  majorVersion,
  input wire logic [3:0]  minorVersion,
  input wire logic [4:0]  sampleDepth,
  input wire logic [4:0]  lineStoreDepth,
  input wire logic [9:0]  targetRate,
  input wire logic        paramValid,
  input wire logic        paramInvalid
);
  // ----------------------------------------------------------------
  // Bus handshake and decoded outputs
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Accepted commit or clear; only these may move decoded outputs
  wire ctrlWr = avs_write && !avs_waitrequest && avs_address[9:2] == 8'h00
                && avs_byteenable[0] && (avs_writedata[1:0] != 2'b00);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest;
  endsequence
  a_one_wait: assert property (s_req |=> s_ack)
    else $error("bus request not answered after one wait cycle");
  a_rate_hold: assert property (!ctrlWr ##1 !ctrlWr |=> $stable(targetRate) && $stable(majorVersion))
    else $error("decoded fields moved without commit");
  a_major_ok: assert property (paramValid |-> majorVersion == `PPU_MAJOR_OK)
    else $error("valid set with bad major version");
  a_minor_ok: assert property (paramValid |-> minorVersion inside {4'h1, 4'h2})
    else $error("valid set with bad minor version");
  a_sample_depth: assert property (paramValid |-> sampleDepth inside {5'd8, 5'd10, 5'd12}
    || (minorVersion == 4'h2 && sampleDepth inside {5'd14, 5'd16}))
    else $error("valid set with disallowed sample depth");
  a_line_depth: assert property (paramValid |-> lineStoreDepth inside {[5'd8:5'd13]}
    || (minorVersion == 4'h2 && lineStoreDepth inside {[5'd14:5'd16]}))
    else $error("valid set with disallowed line depth");
  a_valid_excl: assert property (!(paramValid && paramInvalid))
    else $error("valid and invalid both high");
  a_store_gate: assert property (storedValid |-> $past(reconValid) && $past(paramValid))
    else $error("stored sample without valid set");
endmodule
bind ppu_unpacker ppu_unpacker_asserts uChk (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .reconValid(reconValid),
  .storedValid(storedValid), .majorVersion(majorVersion), .minorVersion(minorVersion),
  .sampleDepth(sampleDepth), .lineStoreDepth(lineStoreDepth), .targetRate(targetRate),
  .paramValid(paramValid), .paramInvalid(paramInvalid));
`default_nettype wire

// *** ppu_encoder_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppu_encoder_model (
  input wire logic [6:0] idx,
  input wire logic [3:0] major,
  input wire logic [3:0] minor,
  input wire logic [7:0] tag,
  input wire logic [3:0] depthCode,
  input wire logic [3:0] lineCode,
  input wire logic [3:0] flags,
  input wire logic [9:0] rate,
  input wire logic       containerMode,
  input wire logic       breakRules,
  output logic     [7:0] pByte
);
  // ----------------------------------------------------------------
  // Byte image of the set; breakRules sets reserved bits on purpose
  // ----------------------------------------------------------------
  always_comb begin
    case (idx)
      7'd0: pByte = {major, minor};
      7'd1: pByte = tag;
      7'd2: pByte = breakRules ? 8'ha5 : 8'h00;
      7'd3: pByte = {depthCode, lineCode};
      // Drop flag kept clear with a container mode unless misbehaving
      7'd4: pByte = {breakRules ? 2'b11 : 2'b00, flags[3:2],
                     flags[1] & (breakRules | ~containerMode), flags[0], rate[9:8]};
      7'd5: pByte = rate[7:0];
      default: pByte = {1'b0, idx} ^ 8'h5a;
    endcase
  end
endmodule
`default_nettype wire

// *** ppu_unpacker_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ppu_defs.vh"
module ppu_unpacker_test;
  logic clk, rst, avs_read, avs_write, chromaContainerMode, reconValid, reconChroma, junk, dr, bad;
  logic [9:0] avs_address, rate;
  logic [31:0] avs_writedata, q;
  logic [3:0] avs_byteenable, major, minor, sc, lc, fl;
  logic [15:0] reconSample, expS;
  bit armed, armedD;
  logic [7:0] tag;
  logic [6:0] idx;
  logic [4:0] sd, ld;
  logic [3:0] sCodes [6] = '{4'h0, 4'h8, 4'ha, 4'hc, 4'he, 4'h3};
  int failures, tests_run;
  wire [31:0] avs_readdata;
  wire [15:0] storedSample;
  wire [9:0] targetRate;
  wire [7:0] setTag, pByte;
  wire [4:0] sampleDepth, lineStoreDepth;
  wire [3:0] majorVersion, minorVersion;
  wire avs_waitrequest, irq, storedValid, blockPredictionEnable, colourConvert, sampleDrop;
  wire variableRate, paramValid, paramInvalid;
  ppu_unpacker dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .chromaContainerMode(chromaContainerMode), .reconSample(reconSample),
    .reconValid(reconValid), .reconChroma(reconChroma), .storedSample(storedSample),
    .storedValid(storedValid), .majorVersion(majorVersion), .minorVersion(minorVersion),
    .setTag(setTag), .sampleDepth(sampleDepth), .lineStoreDepth(lineStoreDepth),
    .blockPredictionEnable(blockPredictionEnable), .colourConvert(colourConvert),
    .sampleDrop(sampleDrop), .variableRate(variableRate), .targetRate(targetRate),
    .paramValid(paramValid), .paramInvalid(paramInvalid));
  ppu_encoder_model enc (.idx(idx), .major(major), .minor(minor), .tag(tag), .depthCode(sc),
    .lineCode(lc), .flags(fl), .rate(rate), .containerMode(chromaContainerMode),
    .breakRules(junk), .pByte(pByte));
  // ----------------------------------------------------------------
  // Clock, recon traffic and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Random samples keep the rounding path busy; checked while a good set is in force
  always @(posedge clk) begin
    reconValid <= $urandom;
    reconSample <= $urandom;
    reconChroma <= $urandom;
    expS <= rnd(reconSample, reconChroma);
    armedD <= armed;
    if (storedValid && armedD) chk(storedSample, expS);
  end
  // Line-store rounding: half up, low bits cleared, capped at the component range
  function automatic logic [15:0] rnd(input logic [15:0] s, input logic c);
    int w, d, r;
    w = sd + int'(fl[2] && c && sd != 5'd16);
    d = (w > ld) ? w - ld : 0;
    r = d ? ((s + (1 << (d - 1))) >> d) << d : s;
    if (r > (1 << w) - 1) r = (((1 << w) - 1) >> d) << d;
    return 16'(r);
  endfunction
  function automatic logic [4:0] sdep(input logic [3:0] c, input logic v2);
    case (c)
      4'h8, 4'ha, 4'hc: return {1'b0, c};
      4'he: return v2 ? 5'd14 : 5'd0;
      4'h0: return v2 ? 5'd16 : 5'd0;
      default: return 5'd0;
    endcase
  endfunction
  function automatic logic [4:0] ldep(input logic [3:0] c, input logic v2);
    if (c >= 4'h8 && c <= 4'hd) return {1'b0, c};
    if (c == 4'h0) return v2 ? 5'd16 : 5'd0;
    return (c >= 4'he && v2) ? {1'b0, c} : 5'd0;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk);
  endtask
  task automatic sendSet(input int last);
    for (int i = 0; i <= last; i++) begin
      idx <= i[6:0];
      @(posedge clk);
      bus(1, 10'h200 + 10'(4 * i), {24'h0, pByte});
    end
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    summarize;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h65abbf8a));
    {avs_read, avs_write, avs_address, avs_writedata, chromaContainerMode, idx, junk} = 0;
    {reconValid, reconSample, reconChroma} = 0;
    {major, minor, sc, lc, fl, rate, tag} = {4'h1, 4'h1, 4'h8, 4'h8, 22'h0};
    avs_byteenable = 4'hf;
    rst = 1;
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk({irq, paramValid}, 0);
    bus(0, `PPU_REG_IRQ_MASK, 0);
    chk(q, 0);
    bus(0, 10'h100, 0);
    chk(q, 0);
    // Commit on an incomplete set is refused
    bus(1, `PPU_REG_CTRL, 1);
    bus(0, `PPU_REG_IRQ_STATUS, 0);
    chk({q[2], paramValid}, 2'b10);
    bus(1, `PPU_REG_IRQ_STATUS, 7);
    sendSet(127);
    bus(1, `PPU_REG_IRQ_MASK, 2);
    $display("Reset and refused commit test done");
    for (int k = 0; k < 36; k++) begin
      armed = 0;
      major = (k == 3) ? 4'h2 : 4'h1;
      minor = (k % 7 == 6) ? 4'h0 : 4'(1 + $urandom % 2);
      sc = sCodes[k % 6];
      lc = $urandom;
      {fl, rate, tag} = $urandom;
      junk = (k % 4 == 1);
      chromaContainerMode <= (k % 5 == 0);
      sendSet(5);
      bus(1, `PPU_REG_CTRL, 1);
      bus(0, `PPU_REG_STATUS, 0);
      dr = fl[1] & (junk | !chromaContainerMode);
      sd = sdep(sc, minor == 4'h2);
      ld = ldep(lc, minor == 4'h2);
      bad = major != 4'h1 || minor == 4'h0 || sd == 0 || ld == 0 || (dr && chromaContainerMode);
      chk(q[2:0], {bad, !bad, 1'b1});
      armed = !bad;
      chk({paramInvalid, paramValid, irq}, {bad, !bad, bad});
      chk({majorVersion, minorVersion, setTag}, {major, minor, tag});
      chk({blockPredictionEnable, colourConvert}, fl[3:2]);
      chk({sampleDrop, variableRate}, {dr, fl[0]});
      chk(targetRate, rate);
      if (!bad) chk({sampleDepth, lineStoreDepth}, {sd, ld});
      bus(0, `PPU_REG_VERSION, 0);
      chk(q[15:0], {tag, major, minor});
      if (junk) begin
        bus(0, `PPU_RESERVED_BYTE, 0);
        chk(q, 0);
        bus(0, `PPU_CODING_FLAGS_BYTE, 0);
        chk(q, {26'h0, fl[3:2], dr, fl[0], rate[9:8]});
      end
      bus(1, `PPU_REG_IRQ_STATUS, 7);
      chk(irq, 0);
    end
    $display("Decode table test done");
    // Clear forgets captured bytes, so a new commit is refused
    bus(1, `PPU_REG_CTRL, 2);
    bus(1, `PPU_REG_CTRL, 1);
    bus(0, `PPU_REG_IRQ_STATUS, 0);
    chk({q[2:0], paramValid}, 4'b1000);
    $display("Clear test done");
    summarize;
  end
endmodule
`default_nettype wire
